// ### rtl/ppd_top.sv
// Purpose: power-down, standby, keeper and programming protection control
// Assumes: core logic next values arrive on CORE_D in the MCLK domain;
//          pins and power-down inputs are asynchronous and synchronised here
// Notes on behaviour
// - power-down option set and either power-down pin high enters power-down; the code enters it from run only, never from programming or lock.
// - in power-down all macrocell state and enabled outputs hold their value.
// - pin transitions are ignored until the power-down pin returns low.
// - with power-down enabled, power-down pins are not logic inputs.
// - standby is entered after idle time and left on any activity.
// - reset clears all registers low; outputs then follow the polarity.
// - with the fuse set, pattern readback is blocked; signature and id stay.
// - interrupted programming locks the part and floats every output.
// - keeper holds the last driven level of a released pin, also programming.
// - each output has slew control, slow by default, fast when set.
// - JTAG port may be disabled to free its pins for logic.
// - reduced-power bit per macrocell adds a fixed delay to its path.
//
// Our own choices: the placing of the registers and the strobed register port.
module ppd_top #(
  parameter int unsigned N = ppd_pkg::NMC
) (
  input  wire logic                   MCLK,
  input  wire logic                   RST,
  input  wire logic [ppd_pkg::AW-1:0] ADDR,
  input  wire logic [31:0]            WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [31:0]            RDATA,
  input  wire logic                   POWER_DOWN_PIN_A,
  input  wire logic                   POWER_DOWN_PIN_B,
  input  wire logic [N-1:0]           CORE_D,
  input  wire logic [N-1:0]           IO_IN,
  input  wire logic [N-1:0]           IO_FLOAT,
  output logic      [N-1:0]           IO_OUT,
  output logic      [N-1:0]           IO_OE,
  output logic      [N-1:0]           IO_SEEN,
  output logic      [N-1:0]           SLEW_FAST,
  output logic      [1:0]             PD_PIN_LOGIC,
  output logic                        JTAG_OFF,
  output logic                        POWERED_DOWN,
  output logic                        STANDBY,
  output logic                        LOCKED
);
  localparam int unsigned CW = $clog2(ppd_pkg::STBY_IDLE_CYC + 1);

  typedef struct packed {
    ppd_pkg::ppd_mode_t mode;
    logic [1:0]         pd_s1;
    logic [1:0]         pd_s2;
    logic [N-1:0]       in_s1;
    logic [N-1:0]       in_s2;
    logic [N-1:0]       fl_s1;
    logic [N-1:0]       fl_s2;
    logic [N-1:0]       kept;
    logic [N-1:0]       seen;
    logic [N-1:0]       mc_q;
    logic [N-1:0]       mc_d1;
    logic [N-1:0]       io_out;
    logic [N-1:0]       io_oe;
    logic [N-1:0]       slew;
    logic [1:0]         pd_logic;
    logic               jtag_off;
    logic               pdn;
    logic               stby;
    logic               lock;
    logic [CW-1:0]      idle;
  } ppd_core_t;

  ppd_core_t s;
  ppd_core_t next_s;
  logic      pd_req;
  logic      frozen;
  logic      act;

  ppd_cfg_if #(.N(N)) cfg ();

  ppd_regs #(.N(N)) u_regs (
    .clk   (MCLK),
    .rst   (RST),
    .addr  (ADDR),
    .wdata (WDATA),
    .wr    (WR),
    .rd    (RD),
    .rdata (RDATA),
    .cfg   (cfg)
  );

  always_comb begin
    next_s = s;
    // two-stage synchronisers; stage one feeds stage two only
    next_s.pd_s1 = {POWER_DOWN_PIN_B, POWER_DOWN_PIN_A};
    next_s.pd_s2 = s.pd_s1;
    next_s.in_s1 = IO_IN;
    next_s.in_s2 = s.in_s1;
    next_s.fl_s1 = IO_FLOAT;
    next_s.fl_s2 = s.fl_s1;

    pd_req = cfg.pd_en && (s.pd_s2 != 2'b00);

    case (s.mode)
      ppd_pkg::MODE_RUN: begin
        // programming request outranks power-down
        if (cfg.prog_start) begin
          next_s.mode = ppd_pkg::MODE_PROG;
        end else if (pd_req) begin
          next_s.mode = ppd_pkg::MODE_PDOWN;
        end
      end
      ppd_pkg::MODE_PDOWN: begin
        // both power-down pins low, or the power-down option cleared, ends the freeze
        if (!pd_req) begin
          next_s.mode = ppd_pkg::MODE_RUN;
        end
      end
      ppd_pkg::MODE_PROG: begin
        if (cfg.prog_abort) begin
          next_s.mode = ppd_pkg::MODE_LOCK;
        end else if (cfg.prog_done) begin
          next_s.mode = ppd_pkg::MODE_RUN;
        end
      end
      ppd_pkg::MODE_LOCK: begin
        // only a fresh programming session leaves the lock
        if (cfg.prog_start) begin
          next_s.mode = ppd_pkg::MODE_PROG;
        end
      end
      default: next_s.mode = ppd_pkg::MODE_RUN;
    endcase

    // freeze takes effect on the same edge as the entry decision
    frozen = (next_s.mode == ppd_pkg::MODE_PDOWN);

    if (!frozen) begin
      for (int i = 0; i < N; i++) begin
        if (!s.fl_s2[i]) begin
          next_s.kept[i] = s.in_s2[i];
          next_s.seen[i] = s.in_s2[i];
        end else begin
          // keeper works in programming too; no keeper means a weak low
          next_s.seen[i] = cfg.keep_en ? s.kept[i] : 1'b0;
        end
      end
      next_s.mc_q  = CORE_D;
      next_s.mc_d1 = s.mc_q;
      // reduced-power cells take the one-cycle-late copy
      next_s.io_out = ((cfg.rpwr & s.mc_d1) | (~cfg.rpwr & s.mc_q)) ^ cfg.pol;
      next_s.io_oe  = (next_s.mode == ppd_pkg::MODE_RUN) ? cfg.oen : '0;
    end

    next_s.pdn  = frozen;
    next_s.lock = (next_s.mode == ppd_pkg::MODE_LOCK);

    // activity watch; a frozen part sees none and drops into standby
    act = (next_s.seen != s.seen) || (next_s.mc_q != s.mc_q);
    if (act) begin
      next_s.idle = '0;
      next_s.stby = 1'b0;
    end else if (s.idle != CW'(ppd_pkg::STBY_IDLE_CYC)) begin
      next_s.idle = s.idle + 1'b1;
    end else begin
      next_s.stby = 1'b1;
    end

    next_s.pd_logic = cfg.pd_en ? 2'b00 : s.pd_s2;
    next_s.slew     = cfg.slew;
    next_s.jtag_off = cfg.jtag_off;
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign IO_OUT       = s.io_out;
  assign IO_OE        = s.io_oe;
  assign IO_SEEN      = s.seen;
  assign SLEW_FAST    = s.slew;
  assign PD_PIN_LOGIC = s.pd_logic;
  assign JTAG_OFF     = s.jtag_off;
  assign POWERED_DOWN = s.pdn;
  assign STANDBY      = s.stby;
  assign LOCKED       = s.lock;

  assign cfg.status = {2'b00, s.pd_logic, s.lock, s.mode == ppd_pkg::MODE_PROG,
                       s.stby, s.pdn};

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  a_pd_entry: assert property (
    s.mode == ppd_pkg::MODE_RUN && cfg.pd_en && s.pd_s2 != 2'b00 && !cfg.prog_start
    |=> POWERED_DOWN && s.mode == ppd_pkg::MODE_PDOWN)
    else $error("power-down not entered");

  a_pd_freeze: assert property (
    s.mode == ppd_pkg::MODE_PDOWN |-> $stable(s.mc_q) && $stable(IO_OUT) && $stable(IO_OE))
    else $error("state moved in power-down");

  a_pd_ignore: assert property (
    s.mode == ppd_pkg::MODE_PDOWN |-> $stable(IO_SEEN))
    else $error("pin change seen in power-down");

  a_pd_exit: assert property (
    s.mode == ppd_pkg::MODE_PDOWN && s.pd_s2 == 2'b00 |=> s.mode == ppd_pkg::MODE_RUN)
    else $error("power-down not left");

  a_pd_pin_logic: assert property (
    cfg.pd_en |=> PD_PIN_LOGIC == 2'b00)
    else $error("power-down pin used as logic");

  a_stby_wake: assert property (
    $changed(IO_SEEN) |-> !STANDBY)
    else $error("standby held through activity");

  a_stby_enter: assert property (
    $stable(IO_SEEN) && $stable(s.mc_q) && s.idle == CW'(ppd_pkg::STBY_IDLE_CYC)
    ##1 ($stable(IO_SEEN) && $stable(s.mc_q)) |-> STANDBY)
    else $error("standby not entered when idle");

  a_reset_clear: assert property (
    $fell(RST) |-> s.mc_q == '0 && IO_OUT == '0 && IO_OE == '0 && s.mode == ppd_pkg::MODE_RUN)
    else $error("registers not cleared by reset");

  a_abort_lock: assert property (
    s.mode == ppd_pkg::MODE_PROG && cfg.prog_abort |=> LOCKED ##0 IO_OE == '0)
    else $error("abort did not lock");

  a_lock_hiz: assert property (
    s.mode == ppd_pkg::MODE_LOCK |-> IO_OE == '0 && LOCKED)
    else $error("output driven while locked");

  a_keeper_hold: assert property (
    cfg.keep_en && s.fl_s2[0] && !frozen |=> IO_SEEN[0] == $past(s.kept[0]))
    else $error("keeper lost level");

  a_rp_delay: assert property (
    $past(s.mode == ppd_pkg::MODE_RUN, 2) && $past(s.mode == ppd_pkg::MODE_RUN)
    && s.mode == ppd_pkg::MODE_RUN && $past(cfg.rpwr[0])
    |-> IO_OUT[0] == ($past(s.mc_q[0], 2) ^ $past(cfg.pol[0])))
    else $error("reduced-power path delay wrong");

  a_pd_off: assert property (
    !cfg.pd_en |=> !POWERED_DOWN)
    else $error("power-down entered while disabled");

  a_prog_wins: assert property (
    s.mode == ppd_pkg::MODE_RUN && cfg.prog_start
    |=> s.mode == ppd_pkg::MODE_PROG && !POWERED_DOWN)
    else $error("programming start lost to power-down");

  a_pd_sync: assert property (
    cfg.pd_en && s.mode == ppd_pkg::MODE_RUN && !cfg.prog_start && s.pd_s2 == 2'b00
    |=> !POWERED_DOWN)
    else $error("power-down without a pin request");

  a_pd_noprog: assert property (
    s.mode == ppd_pkg::MODE_PDOWN && cfg.prog_start
    |=> s.mode != ppd_pkg::MODE_PROG)
    else $error("programming started in power-down");

  a_pd_stay: assert property (
    s.mode == ppd_pkg::MODE_PDOWN && pd_req
    |=> POWERED_DOWN && s.mode == ppd_pkg::MODE_PDOWN)
    else $error("power-down left while pin high");

  a_pd_kept: assert property (
    s.mode == ppd_pkg::MODE_PDOWN |-> $stable(s.kept) && $stable(s.mc_d1))
    else $error("keeper or delay stage moved in power-down");

  a_pd_stby: assert property (
    s.mode == ppd_pkg::MODE_PDOWN && pd_req && s.idle == CW'(ppd_pkg::STBY_IDLE_CYC)
    |=> STANDBY)
    else $error("frozen part not in standby");

  a_stby_core: assert property (
    $changed(s.mc_q) |-> !STANDBY)
    else $error("standby held through core activity");

  a_stby_count: assert property (
    $rose(STANDBY) |-> $past(s.idle) == CW'(ppd_pkg::STBY_IDLE_CYC))
    else $error("standby entered before idle time");

  a_lock_exit: assert property (
    s.mode == ppd_pkg::MODE_LOCK && cfg.prog_start
    |=> s.mode == ppd_pkg::MODE_PROG && !LOCKED)
    else $error("lock not left on new programming");

  a_lock_stay: assert property (
    s.mode == ppd_pkg::MODE_LOCK && !cfg.prog_start
    |=> LOCKED && IO_OE == '0)
    else $error("lock released without programming");

  a_prog_hiz: assert property (
    s.mode == ppd_pkg::MODE_PROG |-> IO_OE == '0)
    else $error("output driven while programming");

  // pass-through paths while nothing is frozen
  a_oe_follow: assert property (
    s.mode == ppd_pkg::MODE_RUN |-> IO_OE == $past(cfg.oen))
    else $error("output enable not following config");

  a_core_take: assert property (
    s.mode != ppd_pkg::MODE_PDOWN |-> s.mc_q == $past(CORE_D))
    else $error("macrocell state not taken");

  a_fast_path: assert property (
    s.mode == ppd_pkg::MODE_RUN && !$past(cfg.rpwr[0])
    |-> IO_OUT[0] == ($past(s.mc_q[0]) ^ $past(cfg.pol[0])))
    else $error("full-power path delay wrong");

  a_pin_follow: assert property (
    !s.fl_s2[0] && !frozen
    |=> IO_SEEN[0] == $past(s.in_s2[0]))
    else $error("driven pin not seen");

  a_kept_take: assert property (
    !s.fl_s2[0] && !frozen
    |=> s.kept[0] == $past(s.in_s2[0]))
    else $error("keeper did not take driven level");

  a_keep_off: assert property (
    !cfg.keep_en && s.fl_s2[0] && !frozen
    |=> IO_SEEN[0] == 1'b0)
    else $error("floating pin held without keeper");

  a_pin_plain: assert property (
    !cfg.pd_en
    |=> PD_PIN_LOGIC == $past(s.pd_s2))
    else $error("power-down pin not plain logic");

  // outputs copied from configuration lag it by exactly one edge
  a_slew_follow: assert property (
    SLEW_FAST == $past(cfg.slew))
    else $error("slew output not following config");

  a_jtag_follow: assert property (
    JTAG_OFF == $past(cfg.jtag_off))
    else $error("port disable not following config");
endmodule

// ### common/ppd_pkg.sv
// Purpose: shared constants and types of the power-down and protection block
// Assumes: 32-bit register words at byte addresses, 100 MHz MCLK
// Notes:   register offsets and bit positions used by regs and bench alike
package ppd_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned NMC = 16;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLEW = 8'h04;
  localparam logic [7:0] OFS_RPWR = 8'h08;
  localparam logic [7:0] OFS_POL  = 8'h0C;
  localparam logic [7:0] OFS_OEN  = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_SIG  = 8'h18;
  localparam logic [7:0] OFS_ID   = 8'h1C;

  localparam int unsigned CTL_PD_EN    = 0;
  localparam int unsigned CTL_KEEP     = 1;
  localparam int unsigned CTL_JTAG_OFF = 2;
  localparam int unsigned CTL_FUSE     = 3;
  localparam int unsigned CTL_PSTART   = 4;
  localparam int unsigned CTL_PDONE    = 5;
  localparam int unsigned CTL_PABORT   = 6;

  localparam int unsigned ST_W    = 8;
  localparam int unsigned ST_FUSE = 6;

  localparam logic [15:0] SIG_RST = 16'h0000;
  // arbitrary value, names no real part
  localparam logic [31:0] DEV_ID  = 32'h0000_5A01;

  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned STBY_IDLE_NS  = 160;
  localparam int unsigned STBY_IDLE_CYC = STBY_IDLE_NS * CLK_MHZ / 1000;

  typedef enum logic [1:0] {MODE_RUN, MODE_PDOWN, MODE_PROG, MODE_LOCK} ppd_mode_t;
endpackage

// ### common/ppd_cfg_if.sv
// Purpose: configuration and status carried between register file and core
// Assumes: both ends on MCLK
// Notes:   prog_* are one-cycle pulses
interface ppd_cfg_if #(parameter int unsigned N = 16);
  logic                     pd_en;
  logic                     keep_en;
  logic                     jtag_off;
  logic                     fuse;
  logic [N-1:0]             slew;
  logic [N-1:0]             rpwr;
  logic [N-1:0]             pol;
  logic [N-1:0]             oen;
  logic                     prog_start;
  logic                     prog_done;
  logic                     prog_abort;
  logic [ppd_pkg::ST_W-1:0] status;
  modport regs (output pd_en, keep_en, jtag_off, fuse, slew, rpwr, pol, oen,
                output prog_start, prog_done, prog_abort, input status);
  modport core (input pd_en, keep_en, jtag_off, fuse, slew, rpwr, pol, oen,
                input prog_start, prog_done, prog_abort, output status);
endinterface

// ### rtl/ppd_regs.sv
// Purpose: register file on the plain strobe port
// Assumes: strobes one cycle, never together; read data valid next cycle only
// Notes:   fuse hides slew, rpwr, pol and oen readback; control, signature and id stay open
module ppd_regs #(
  parameter int unsigned N = 16
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [ppd_pkg::AW-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [31:0]            rdata,
  ppd_cfg_if.regs                     cfg
);
  typedef struct packed {
    logic        pd_en;
    logic        keep_en;
    logic        jtag_off;
    logic        fuse;
    logic [N-1:0] slew;
    logic [N-1:0] rpwr;
    logic [N-1:0] pol;
    logic [N-1:0] oen;
    logic [15:0] sig;
    logic        ps;
    logic        pd;
    logic        pa;
    logic [31:0] rdata;
  } ppd_regs_t;

  ppd_regs_t s;
  ppd_regs_t next_s;

  always_comb begin
    next_s = s;
    next_s.ps = 1'b0;
    next_s.pd = 1'b0;
    next_s.pa = 1'b0;
    next_s.rdata = 32'h0000_0000;
    if (wr) begin
      case (addr)
        ppd_pkg::OFS_CTRL: begin
          next_s.pd_en    = wdata[ppd_pkg::CTL_PD_EN];
          next_s.keep_en  = wdata[ppd_pkg::CTL_KEEP];
          next_s.jtag_off = wdata[ppd_pkg::CTL_JTAG_OFF];
          // fuse only ever sets; clearing needs a full reset
          next_s.fuse     = s.fuse | wdata[ppd_pkg::CTL_FUSE];
          next_s.ps       = wdata[ppd_pkg::CTL_PSTART];
          next_s.pd       = wdata[ppd_pkg::CTL_PDONE];
          next_s.pa       = wdata[ppd_pkg::CTL_PABORT];
        end
        ppd_pkg::OFS_SLEW: next_s.slew = wdata[N-1:0];
        ppd_pkg::OFS_RPWR: next_s.rpwr = wdata[N-1:0];
        ppd_pkg::OFS_POL:  next_s.pol  = wdata[N-1:0];
        ppd_pkg::OFS_OEN:  next_s.oen  = wdata[N-1:0];
        ppd_pkg::OFS_SIG:  next_s.sig  = wdata[15:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        ppd_pkg::OFS_CTRL: next_s.rdata = 32'({s.fuse, s.jtag_off, s.keep_en, s.pd_en});
        ppd_pkg::OFS_SLEW: next_s.rdata = s.fuse ? 32'h0 : 32'(s.slew);
        ppd_pkg::OFS_RPWR: next_s.rdata = s.fuse ? 32'h0 : 32'(s.rpwr);
        ppd_pkg::OFS_POL:  next_s.rdata = s.fuse ? 32'h0 : 32'(s.pol);
        ppd_pkg::OFS_OEN:  next_s.rdata = s.fuse ? 32'h0 : 32'(s.oen);
        ppd_pkg::OFS_STAT: next_s.rdata = 32'(cfg.status | (8'h01 << ppd_pkg::ST_FUSE) & {8{s.fuse}});
        ppd_pkg::OFS_SIG:  next_s.rdata = 32'(s.sig);
        ppd_pkg::OFS_ID:   next_s.rdata = ppd_pkg::DEV_ID;
        default:           next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s     <= '0;
      s.sig <= ppd_pkg::SIG_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rdata          = s.rdata;
  assign cfg.pd_en      = s.pd_en;
  assign cfg.keep_en    = s.keep_en;
  assign cfg.jtag_off   = s.jtag_off;
  assign cfg.fuse       = s.fuse;
  assign cfg.slew       = s.slew;
  assign cfg.rpwr       = s.rpwr;
  assign cfg.pol        = s.pol;
  assign cfg.oen        = s.oen;
  assign cfg.prog_start = s.ps;
  assign cfg.prog_done  = s.pd;
  assign cfg.prog_abort = s.pa;

  a_slew_default: assert property (@(posedge clk) $fell(rst) |-> s.slew == '0)
    else $error("slew not slow after reset");
  a_fuse_block: assert property (@(posedge clk) disable iff (rst)
    rd && s.fuse && addr == ppd_pkg::OFS_POL |=> rdata == 32'h0)
    else $error("pattern readable with fuse set");
  a_sig_open: assert property (@(posedge clk) disable iff (rst)
    rd && addr == ppd_pkg::OFS_SIG |=> rdata == 32'($past(s.sig)))
    else $error("signature not readable");
endmodule

// ### sim/ppd_board.sv
// Purpose: board-side model driving power-down pins, pins and core data
// Assumes: bench commands on MCLK, one register stage like real board logic
// Notes:   a released pin shows the inverse of its last level (no pull)
module ppd_board #(
  parameter int unsigned N = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [1:0]   pd_req,
  input  wire logic [N-1:0] lvl,
  input  wire logic [N-1:0] rel,
  input  wire logic [N-1:0] core,
  output logic              pin_a,
  output logic              pin_b,
  output logic      [N-1:0] io_in,
  output logic      [N-1:0] io_float,
  output logic      [N-1:0] core_d
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [N-1:0] last;
  // quiet in reset, changes just after edges so setup always holds
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      io_in <= '0;
      io_float <= '0;
      core_d <= '0;
      last <= '0;
    end else begin
      {pin_b, pin_a} <= pd_req;
      last <= (lvl & ~rel) | (last & rel);
      // no keeper on the board side: a floating line must not look held
      io_in <= (lvl & ~rel) | (~last & rel);
      io_float <= rel;
      core_d <= core;
    end
  end
endmodule

// ### sim/tb_top.sv
// Purpose: self-checking bench of the power-down and protection block
// Assumes: MCLK 100 MHz, polarity 00FF kept after the reset scenario
// Notes:   fuse scenario runs last, only reset clears the fuse
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned N = ppd_pkg::NMC;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic PIN_A, PIN_B, JTAG_OFF, POWERED_DOWN, STANDBY, LOCKED;
  logic [N-1:0] CORE_D, IO_IN, IO_FLOAT, IO_OUT, IO_OE, IO_SEEN, SLEW_FAST;
  logic [1:0] PD_PIN_LOGIC;
  logic [1:0] pd_req = 2'h0;
  logic [N-1:0] lvl = 16'h0, rel = 16'h0, core = 16'h0;
  int n_fail = 0;
  int n_tests = 0;

  always #5 MCLK = ~MCLK;

  ppd_top #(.N(N)) uut (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .POWER_DOWN_PIN_A(PIN_A),
    .POWER_DOWN_PIN_B(PIN_B), .CORE_D(CORE_D), .IO_IN(IO_IN),
    .IO_FLOAT(IO_FLOAT), .IO_OUT(IO_OUT), .IO_OE(IO_OE), .IO_SEEN(IO_SEEN),
    .SLEW_FAST(SLEW_FAST), .PD_PIN_LOGIC(PD_PIN_LOGIC), .JTAG_OFF(JTAG_OFF),
    .POWERED_DOWN(POWERED_DOWN), .STANDBY(STANDBY), .LOCKED(LOCKED));

  ppd_board #(.N(N)) board (.clk(MCLK), .rst(RST), .pd_req(pd_req), .lvl(lvl),
    .rel(rel), .core(core), .pin_a(PIN_A), .pin_b(PIN_B), .io_in(IO_IN),
    .io_float(IO_FLOAT), .core_d(CORE_D));

  task automatic stop_test();
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    chk(nm, e, RDATA);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return POWERED_DOWN;
      1: return STANDBY;
      default: return LOCKED;
    endcase
  endfunction

  // bounded wait on a status flag; running out ends the run
  task automatic wt(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge MCLK);
      #1;
      if (sig(s) === v) return;
    end
    $display("mismatch flag%0d exp %b got %b", s, v, sig(s));
    n_fail++;
    stop_test();
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  task automatic t_reset();
    chk("out", 32'h0, IO_OUT);
    chk("slew", 32'h0, SLEW_FAST);
    rd(ppd_pkg::OFS_ID, ppd_pkg::DEV_ID, "id");
    wr(8'h40, 32'hFFFF);
    rd(8'h40, 32'h0, "unmapped");
    wr(ppd_pkg::OFS_POL, 32'h00FF);
    settle(3);
    chk("pol", 32'h00FF, IO_OUT);
  endtask

  task automatic t_cfg();
    wr(ppd_pkg::OFS_SLEW, 32'h0081);
    wr(ppd_pkg::OFS_CTRL, 32'h1 << ppd_pkg::CTL_JTAG_OFF);
    settle(3);
    chk("slew", 32'h0081, SLEW_FAST);
    chk("jtag", 32'h1, JTAG_OFF);
    rd(ppd_pkg::OFS_SLEW, 32'h0081, "slew rd");
    wr(ppd_pkg::OFS_CTRL, 32'h0);
  endtask

  task automatic t_pd();
    logic [N-1:0] o, s;
    @(posedge MCLK);
    core <= 16'h0F0F;
    lvl <= 16'h3C3C;
    pd_req <= 2'h1;
    settle(6);
    chk("pd off", 32'h0, POWERED_DOWN);
    chk("pin logic", 32'h1, PD_PIN_LOGIC);
    wr(ppd_pkg::OFS_CTRL, 32'h1 << ppd_pkg::CTL_PD_EN);
    wt(0, 1'b1, 6);
    chk("pin gated", 32'h0, PD_PIN_LOGIC);
    o = IO_OUT;
    s = IO_SEEN;
    @(posedge MCLK);
    core <= 16'hFFFF;
    lvl <= 16'hFFFF;
    settle(6);
    chk("frozen out", o, IO_OUT);
    chk("frozen in", s, IO_SEEN);
    @(posedge MCLK);
    pd_req <= 2'h0;
    wt(0, 1'b0, 8);
    settle(4);
    chk("thawed", 32'hFF00, IO_OUT);
    @(posedge MCLK);
    pd_req <= 2'h2;
    wt(0, 1'b1, 8);
    @(posedge MCLK);
    pd_req <= 2'h0;
    wt(0, 1'b0, 8);
    wr(ppd_pkg::OFS_CTRL, 32'h0);
  endtask

  task automatic t_keep();
    wr(ppd_pkg::OFS_CTRL, 32'h1 << ppd_pkg::CTL_KEEP);
    @(posedge MCLK);
    lvl <= 16'hA5C3;
    settle(5);
    chk("seen", 32'hA5C3, IO_SEEN);
    @(posedge MCLK);
    rel <= 16'hFFFF;
    settle(6);
    chk("kept", 32'hA5C3, IO_SEEN);
    wr(ppd_pkg::OFS_CTRL, 32'h0);
    settle(4);
    chk("unkept", 32'h0, IO_SEEN);
    @(posedge MCLK);
    rel <= 16'h0;
  endtask

  task automatic t_stby();
    @(posedge MCLK);
    core <= 16'h0001;
    settle(10);
    chk("busy", 32'h0, STANDBY);
    wt(1, 1'b1, 20);
    @(posedge MCLK);
    core <= 16'h0002;
    wt(1, 1'b0, 4);
  endtask

  task automatic lat(output int n);
    @(posedge MCLK);
    core <= 16'h0;
    repeat (4) @(posedge MCLK);
    core <= 16'h1234;
    #1;
    n = 0;
    while (n < 10 && IO_OUT !== (16'h1234 ^ 16'h00FF)) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    if (n == 10) begin
      $display("mismatch io_out exp %h got %h", 16'h1234 ^ 16'h00FF, IO_OUT);
      n_fail++;
      stop_test();
    end
  endtask

  task automatic t_rpwr();
    int a, b;
    lat(a);
    wr(ppd_pkg::OFS_RPWR, 32'hFFFF);
    lat(b);
    chk("rp delay", a + 1, b);
    wr(ppd_pkg::OFS_RPWR, 32'h0);
  endtask

  task automatic t_prog();
    wr(ppd_pkg::OFS_OEN, 32'hFFFF);
    settle(3);
    chk("oe run", 32'hFFFF, IO_OE);
    wr(ppd_pkg::OFS_CTRL, 32'h1 << ppd_pkg::CTL_PSTART);
    settle(3);
    chk("oe prog", 32'h0, IO_OE);
    wr(ppd_pkg::OFS_CTRL, 32'h1 << ppd_pkg::CTL_PABORT);
    wt(2, 1'b1, 4);
    chk("oe lock", 32'h0, IO_OE);
    wr(ppd_pkg::OFS_CTRL, 32'h1 << ppd_pkg::CTL_PSTART);
    wr(ppd_pkg::OFS_CTRL, 32'h1 << ppd_pkg::CTL_PDONE);
    wt(2, 1'b0, 4);
    settle(2);
    chk("oe back", 32'hFFFF, IO_OE);
  endtask

  task automatic t_fuse();
    wr(ppd_pkg::OFS_SIG, 32'hBEEF);
    wr(ppd_pkg::OFS_CTRL, 32'h1 << ppd_pkg::CTL_FUSE);
    rd(ppd_pkg::OFS_SLEW, 32'h0, "slew hidden");
    rd(ppd_pkg::OFS_POL, 32'h0, "pol hidden");
    rd(ppd_pkg::OFS_SIG, 32'hBEEF, "signature");
    rd(ppd_pkg::OFS_ID, ppd_pkg::DEV_ID, "id fused");
    rd(ppd_pkg::OFS_CTRL, 32'h8, "ctrl");
  endtask

  initial begin
    repeat (5) @(posedge MCLK);
    RST <= 1'b0;
    // pin synchronisers need two more edges
    settle(3);
    t_reset();
    t_cfg();
    t_pd();
    t_keep();
    t_stby();
    t_rpwr();
    t_prog();
    t_fuse();
    stop_test();
  end
endmodule
